// ===== hw/pll_ref_clock_switchover.sv
`timescale 1ns/1ps
`default_nettype none
module pll_ref_clock_switchover
  import ref_switch_pkg::*;
#(
  parameter int LOSS_CYCLES = LOSS_CYCLES_DEFAULT
) (
  // System clock and reset.
  input wire logic i_clk,
  input wire logic i_resetn,
  // Reference inputs.
  input wire logic i_ref_clock_primary,
  input wire logic i_ref_clock_backup,
  // Control.
  input wire logic [1:0] i_mode,
  input wire logic [DELAY_W-1:0] i_switch_delay,
  input wire logic i_switch_req_n,
  input wire logic i_pll_locked,
  // Status and clock out.
  output logic o_ref_clock_out,
  output logic o_active_clock,
  output logic o_clock_fail_flag_0,
  output logic o_clock_fail_flag_1,
  output logic o_switching,
  output logic o_pll_reset,
  output logic o_outputs_enable
);

  ref_status_s mon [2];
  logic req_meta;
  logic req_sync;
  logic req_prev;
  logic req_fall;
  logic req_rise;
  logic armed;
  logic [LOW_CNT_W-1:0] low_count;
  logic [LOW_CNT_W-1:0] low_needed;
  logic active;
  logic target;
  logic gate;
  state_e state;
  logic manual_go;
  logic auto_go;
  logic [1:0] rst_count;
  logic lock_meta;
  logic lock_sync;
  logic [3:0] lock_count;

  // One monitor per reference input.
  generate
    for (genvar i = 0; i < 2; i++) begin : g_mon
      ref_clock_monitor #(.LOSS_CYCLES(LOSS_CYCLES)) u_mon (
        .i_clk(i_clk),
        .i_resetn(i_resetn),
        .i_ref(i == 0 ? i_ref_clock_primary : i_ref_clock_backup),
        .o_status(mon[i])
      );
    end
  endgenerate

  // The request is a pin; two flops keep metastability out of the counter.
  always_ff @(posedge i_clk) begin
    if (!i_resetn) begin
      req_meta <= 1'b1;
      req_sync <= 1'b1;
      req_prev <= 1'b1;
    end else begin
      req_meta <= i_switch_req_n;
      req_sync <= req_meta;
      req_prev <= req_sync;
    end
  end

  assign req_fall = req_prev & ~req_sync;
  assign req_rise = ~req_prev & req_sync;
  assign target = ~active;
  assign low_needed = LOW_CNT_W'(MIN_LOW_CYCLES) + LOW_CNT_W'(i_switch_delay);

  // A falling request outside automatic mode arms one switch; staying low never re-arms, so the
  // far side must raise it first. Target cycles are counted while low.
  always_ff @(posedge i_clk) begin
    if (!i_resetn) begin
      armed <= 1'b0;
      low_count <= '0;
    end else if (req_fall && i_mode != MODE_AUTO) begin
      armed <= 1'b1;
      low_count <= '0;
    end else if (req_rise || manual_go) begin
      armed <= 1'b0;
      low_count <= '0;
    end else if (armed && mon[target].fall && low_count != low_needed) begin
      low_count <= low_count + LOW_CNT_W'(1);
    end
  end

  assign manual_go = armed && !req_sync && low_count == low_needed && state == ST_IDLE;
  // A low request in override mode blocks automatic action.
  assign auto_go = state == ST_IDLE && mon[active].fail && !mon[target].fail &&
                   (i_mode == MODE_AUTO || (i_mode == MODE_OVERRIDE && req_sync));

  // Switch sequence: gate off on the current input, move on the target.
  always_ff @(posedge i_clk) begin
    if (!i_resetn) begin
      state <= ST_IDLE;
      active <= SEL_PRIMARY;
      gate <= 1'b1;
    end else begin
      unique case (state)
        ST_IDLE: begin
          if (manual_go || auto_go) begin
            state <= ST_GATE;
          end
        end
        ST_GATE: begin
          // A dead input has no falling edge left, so its loss gates at once.
          if (mon[active].fall || mon[active].fail) begin
            gate <= 1'b0;
            state <= ST_MUX;
          end
        end
        ST_MUX: begin
          // Stays here as long as the target is absent.
          if (mon[target].fall && !mon[target].fail) begin
            active <= target;
            gate <= 1'b1;
            state <= ST_IDLE;
          end
        end
        default: begin
          state <= ST_IDLE;
        end
      endcase
    end
  end

  // Registered outputs; the clock out is the sampled, gated, selected input.
  always_ff @(posedge i_clk) begin
    if (!i_resetn) begin
      o_ref_clock_out <= 1'b0;
      o_active_clock <= SEL_PRIMARY;
      o_clock_fail_flag_0 <= 1'b0;
      o_clock_fail_flag_1 <= 1'b0;
      o_switching <= 1'b0;
    end else begin
      o_ref_clock_out <= gate & mon[active].level;
      o_active_clock <= active;
      o_clock_fail_flag_0 <= i_mode != MODE_MANUAL && mon[0].fail;
      o_clock_fail_flag_1 <= i_mode != MODE_MANUAL && mon[1].fail;
      o_switching <= state != ST_IDLE;
    end
  end

  // PLL reset pulse after each completed switch, so the far side gets it.
  always_ff @(posedge i_clk) begin
    if (!i_resetn) begin
      rst_count <= '0;
      o_pll_reset <= 1'b0;
    end else if (state == ST_MUX && mon[target].fall && !mon[target].fail) begin
      rst_count <= 2'(PLL_RESET_CYCLES);
      o_pll_reset <= 1'b1;
    end else if (rst_count != 2'h0) begin
      rst_count <= rst_count - 2'h1;
    end else begin
      o_pll_reset <= 1'b0;
    end
  end

  // Outputs enable only once lock has stayed high for a while after reset.
  always_ff @(posedge i_clk) begin
    if (!i_resetn) begin
      lock_meta <= 1'b0;
      lock_sync <= 1'b0;
      lock_count <= '0;
      o_outputs_enable <= 1'b0;
    end else begin
      lock_meta <= i_pll_locked;
      lock_sync <= lock_meta;
      if (!lock_sync || o_pll_reset || state != ST_IDLE) begin
        lock_count <= '0;
        o_outputs_enable <= 1'b0;
      end else if (lock_count != 4'(LOCK_STABLE_CYCLES)) begin
        lock_count <= lock_count + 4'h1;
      end else begin
        o_outputs_enable <= 1'b1;
      end
    end
  end

  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_resetn);

  sequence s_mux_done;
    state == ST_MUX ##1 state == ST_IDLE;
  endsequence

  a_gate_on_fall: assert property (
    state == ST_GATE && mon[active].fall |=> !gate && state == ST_MUX)
    else $error("gate not closed on current falling edge");

  a_mux_on_target: assert property (
    state == ST_MUX && mon[target].fall && !mon[target].fail |=> active == $past(target) ##1
    o_active_clock == active)
    else $error("selection not moved on target falling edge");

  a_manual_needs_low: assert property (
    state == ST_IDLE && i_mode == MODE_MANUAL ##1 state == ST_GATE |->
    !$past(req_sync) && $past(low_count) == $past(low_needed))
    else $error("manual switch started without enough low cycles");

  a_rise_no_return: assert property (
    req_rise && state == ST_IDLE && !auto_go |=> state == ST_IDLE [*2])
    else $error("rising request started a switch");

  a_wait_target: assert property (
    state == ST_MUX && mon[target].fail |=> state == ST_MUX && active == $past(active))
    else $error("switch completed onto an absent input");

  a_reset_primary: assert property (
    $rose(i_resetn) |-> o_active_clock == SEL_PRIMARY && active == SEL_PRIMARY)
    else $error("primary not selected after reset");

  a_fail_flag: assert property (
    mon[0].fail && i_mode != MODE_MANUAL |=> o_clock_fail_flag_0)
    else $error("fail flag 0 missing for stopped input");

  a_auto_switch: assert property (
    i_mode == MODE_AUTO && auto_go |=> state == ST_GATE ##[1:40] state == ST_MUX)
    else $error("automatic switch did not proceed");

  a_active_reports: assert property (
    s_mux_done |=> o_active_clock != $past(o_active_clock, 2))
    else $error("active flag did not follow the switch");

endmodule // pll_ref_clock_switchover
`default_nettype wire

// ===== hw/ref_clock_monitor.sv
`timescale 1ns/1ps
`default_nettype none
module ref_clock_monitor
  import ref_switch_pkg::*;
#(
  parameter int LOSS_CYCLES = LOSS_CYCLES_DEFAULT
) (
  // System clock and reset.
  input wire logic i_clk,
  input wire logic i_resetn,
  // Reference input pin.
  input wire logic i_ref,
  // Sampled view of the input.
  output ref_status_s o_status
);

  localparam int CW = $clog2(LOSS_CYCLES + 1);
  localparam logic [CW-1:0] LOSS_LIMIT = CW'(LOSS_CYCLES);

  logic ref_meta;
  logic ref_sync;
  logic ref_prev;
  logic [CW-1:0] idle_count;
  logic fail;

  // Two flops before any logic looks at the pin, a third for edges.
  always_ff @(posedge i_clk) begin
    if (!i_resetn) begin
      ref_meta <= 1'b0;
      ref_sync <= 1'b0;
      ref_prev <= 1'b0;
    end else begin
      ref_meta <= i_ref;
      ref_sync <= ref_meta;
      ref_prev <= ref_sync;
    end
  end

  // A stopped input shows as no edge for LOSS_CYCLES system cycles; this limit
  // stands for about two reference periods and must be sized to the slow clock.
  always_ff @(posedge i_clk) begin
    if (!i_resetn) begin
      idle_count <= '0;
      fail <= 1'b0;
    end else if (ref_sync != ref_prev) begin
      idle_count <= '0;
      fail <= 1'b0;
    end else if (idle_count != LOSS_LIMIT) begin
      idle_count <= idle_count + CW'(1);
    end else begin
      fail <= 1'b1;
    end
  end

  assign o_status.level = ref_sync;
  assign o_status.fall = ref_prev & ~ref_sync;
  assign o_status.fail = fail;

endmodule // ref_clock_monitor
`default_nettype wire

// ===== hw/ref_switch_pkg.sv
// What this block does
// - Override mode accepts active-low switch request
// - Gate counter reference on current falling edge
// - Mux and flag move on target falling edge
// - Manual request flips selection, flags stay low
// - Only request falling edge acts; rising ignored
// - Switch waits until target input toggles
// - Manual mode starts on primary input
// - Manual switch needs three target cycles low
// - Configured delay adds cycles to low time
// - Automatic mode flags a stopped input
// - Flag after about two cycles, then switch
// - Selected flag names input feeding PLL
package ref_switch_pkg;

  // Operating modes of the switchover control.
  typedef enum logic [1:0] {
    MODE_MANUAL = 2'b00,
    MODE_AUTO = 2'b01,
    MODE_OVERRIDE = 2'b10
  } mode_e;

  // Switchover sequence states.
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_GATE = 2'b01,
    ST_MUX = 2'b10
  } state_e;

  // Per-input view produced by each clock monitor.
  typedef struct packed {
    logic level;
    logic fall;
    logic fail;
  } ref_status_s;

  localparam int CLK_PERIOD_NS = 10;
  localparam int MIN_LOW_CYCLES = 3;
  localparam int DELAY_W = 8;
  localparam int LOW_CNT_W = DELAY_W + 1;
  localparam int LOSS_CYCLES_DEFAULT = 16;
  localparam int PLL_RESET_NS = 10;
  localparam int PLL_RESET_CYCLES = (PLL_RESET_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int LOCK_STABLE_CYCLES = 8;
  localparam logic SEL_PRIMARY = 1'b0;

endpackage

// ===== testbench/pll_ref_clock_switchover_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module pll_ref_clock_switchover_tb_top;
  import ref_switch_pkg::*;
  logic clk = 1'b0;
  logic resetn = 1'b0;
  logic p = 1'b0;
  logic b = 1'b0;
  logic p_en = 1'b1;
  logic [1:0] mode = 2'b00;
  logic [7:0] dly = 8'h00;
  logic go = 1'b0;
  logic [7:0] lows = 8'h00;
  logic req_n, busy, locked, rclk, act, f0, f1, sw, prst, oen;
  int n_errors = 0;
  int total_checks = 0;
  int n_rst_cycles = 0;
  int n_sw_cycles = 0;
  int n_clk_high = 0;

  // Clocks; the references are slow enough for the sampled monitors, and their
  // periods lie within 20 percent of each other so automatic mode is trusted.
  always #5 clk = ~clk;
  always #80 p = p_en ? ~p : 1'b0;
  always #90 b = ~b;

  pll_ref_clock_switchover #(.LOSS_CYCLES(32)) i_pll_ref_clock_switchover (
    .i_clk(clk), .i_resetn(resetn), .i_ref_clock_primary(p), .i_ref_clock_backup(b),
    .i_mode(mode), .i_switch_delay(dly), .i_switch_req_n(req_n), .i_pll_locked(locked),
    .o_ref_clock_out(rclk), .o_active_clock(act), .o_clock_fail_flag_0(f0),
    .o_clock_fail_flag_1(f1), .o_switching(sw), .o_pll_reset(prst), .o_outputs_enable(oen));

  switch_requester i_switch_requester (
    .i_clk(clk), .i_resetn(resetn), .i_target(act ? p : b), .i_go(go), .i_low_cycles(lows),
    .i_pll_reset(prst), .o_req_n(req_n), .o_busy(busy), .o_locked(locked));

  // Cycles seen with the PLL reset and the switching flag high, for the closing checks.
  always @(posedge clk) begin
    if (prst === 1'b1) begin
      n_rst_cycles++;
    end
    if (sw === 1'b1) begin
      n_sw_cycles++;
    end
  end

  task automatic chk(input logic a, input logic e, input string m);
    total_checks++;
    if (a !== e) begin
      n_errors++;
      $display("mismatch at %0t: %s", $time, m);
    end
  endtask

  // One request held low for n target falls, then time for the switch to land.
  task automatic pulse(input logic [7:0] n);
    @(posedge clk) go <= 1'b1;
    lows <= n;
    @(posedge clk) go <= 1'b0;
    repeat (2000) @(posedge clk) if (!busy) break;
    chk(busy, 1'b0, "request never released");
    repeat (150) @(posedge clk);
  endtask

  task automatic finish_test();
    $display("checks %0d errors %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask

  // A hang is cut short well beyond the expected run length.
  initial begin
    #300us;
    n_errors++;
    finish_test();
  end

  initial begin
    repeat (3) @(posedge clk);
    resetn <= 1'b1;
    repeat (20) @(posedge clk);
    chk(act, 1'b0, "not on primary after reset");
    chk(sw, 1'b0, "switching after reset");
    pulse(8'h02);
    chk(act, 1'b0, "short pulse switched");
    pulse(8'h05);
    chk(act, 1'b1, "no switch to backup");
    chk(sw, 1'b0, "switch sequence left running");
    pulse(8'h1E);
    chk(act, 1'b0, "long low repeated or rise switched back");
    dly <= 8'h03;
    pulse(8'h04);
    chk(act, 1'b0, "switched before delay ran out");
    pulse(8'h09);
    chk(act, 1'b1, "no switch after delay");
    dly <= 8'h00;
    mode <= 2'b10;
    pulse(8'h05);
    chk(act, 1'b0, "override request did not toggle");
    chk(f0 | f1, 1'b0, "fail flag while both run");
    mode <= 2'b01;
    p_en <= 1'b0;
    repeat (300) @(posedge clk);
    chk(f0, 1'b1, "stopped primary not flagged");
    chk(f1, 1'b0, "running backup flagged");
    chk(act, 1'b1, "no move to backup");
    chk(oen, 1'b1, "outputs not enabled after relock");
    chk(n_rst_cycles == 5 * (PLL_RESET_CYCLES + 1), 1'b1, "PLL reset cycle count wrong");
    chk(n_sw_cycles > 0, 1'b1, "switching flag never raised");
    repeat (40) begin
      @(posedge clk);
      if (rclk === 1'b1) n_clk_high++;
    end
    chk(n_clk_high > 0 && n_clk_high < 40, 1'b1, "clock out not following backup");
    finish_test();
  end
endmodule // pll_ref_clock_switchover_tb_top
`default_nettype wire

// ===== testbench/switch_requester.sv
`timescale 1ns/1ps
`default_nettype none
module switch_requester (
  // Clock, reset and sampled target input.
  input wire logic i_clk,
  input wire logic i_resetn,
  input wire logic i_target,
  // Command from the bench, and the PLL reset from the switchover.
  input wire logic i_go,
  input wire logic [7:0] i_low_cycles,
  input wire logic i_pll_reset,
  // Request and lock.
  output logic o_req_n,
  output logic o_busy,
  output logic o_locked
);
  logic prev;
  logic [7:0] cnt;
  logic [4:0] lock_cnt;

  // The request drops only while both inputs run, and rises before the next one.
  always @(posedge i_clk) begin
    if (!i_resetn) begin
      prev <= 1'b0;
      cnt <= 8'h00;
      o_req_n <= 1'b1;
      o_busy <= 1'b0;
    end else begin
      prev <= i_target;
      if (i_go && !o_busy) begin
        o_req_n <= 1'b0;
        o_busy <= 1'b1;
        cnt <= i_low_cycles;
      end else if (o_busy && prev && !i_target) begin
        if (cnt <= 8'h01) begin
          o_req_n <= 1'b1;
          o_busy <= 1'b0;
        end
        cnt <= cnt - 8'h01;
      end
    end
  end

  // The loop relocks a while after each reset, so enabling must wait for it.
  // A known count from reset keeps the lock from showing up before any edge.
  always @(posedge i_clk) begin
    if (!i_resetn || i_pll_reset) begin
      lock_cnt <= 5'h00;
      o_locked <= 1'b0;
    end else if (lock_cnt != 5'h10) begin
      lock_cnt <= lock_cnt + 5'h01;
    end else begin
      o_locked <= 1'b1;
    end
  end
endmodule // switch_requester
`default_nettype wire
